// ==== hdl/fsbc_top.sv ====
// Security byte, lock levels, programming gates and fetch routing
`timescale 1ns/10ps

// Notes on behaviour
// - Boot at 0000h if jump bit set, else F400h
// - Delivered byte: loader boot, standard, 32 MHz, level 4
// - Lock bits one unprogrammed; all unprogrammed is level 1
// - Level 2: hide internal bytes, latch pin, no parallel programming
// - Level 3: adds no parallel verify, no serial programming
// - Level 4: adds no external execution
// - Chip erase clears flash and security byte
// - Part identity readable at every level
// - Hardware locks govern parallel, and serial loader programming from level 3; software byte IN_SYSTEM_PROGRAMMING
// - Extra array defaults FCh, B8h, FFh
// - Software byte: locks in bits 1-0, reserved kept
// - Software level 2 refuses IN_SYSTEM_PROGRAMMING programming
// - Software level 3 also refuses IN_SYSTEM_PROGRAMMING verify
// - Pin high: internal, external above part top
// - Pin low: every fetch external
// - Clock-mode bit clear selects six clocks
module fsbc_top
  import fsbc_pkg::*;
#(
  parameter logic        LARGE_PART = 1'b1,          // 32K part when set
  parameter logic [31:0] ID_BYTES   = 32'h1234_5678  // Arbitrary identity bytes
)(
  input  wire logic          core_clk,
  input  wire logic          reset_n,
  input  wire logic          resample_req,
  input  wire logic          external_access_pin,
  input  wire logic          fetch_req,
  input  wire logic [15:0]   fetch_pc,
  input  wire logic          code_read_req,
  input  wire logic [15:0]   code_read_addr,
  input  wire logic          code_read_from_ext,
  input  wire logic          pp_req,
  input  wire fsbc_pp_cmd_t  pp_cmd,
  input  wire logic [2:0]    pp_index,
  input  wire logic [7:0]    pp_wdata,
  input  wire logic          isp_req,
  input  wire fsbc_isp_cmd_t isp_cmd,
  input  wire logic          isp_api,
  input  wire logic [2:0]    isp_index,
  input  wire logic [7:0]    isp_wdata,
  output logic               pp_done,
  output logic               pp_grant,
  output logic               pp_refused,
  output logic [7:0]         pp_rdata,
  output logic               isp_done,
  output logic               isp_grant,
  output logic               isp_refused,
  output logic [7:0]         isp_rdata,
  output logic               fetch_external,
  output logic               fetch_denied,
  output logic               code_read_denied,
  output logic [15:0]        boot_addr,
  output logic               double_speed_select,
  output logic [1:0]         oscillator_range,
  output logic [1:0]         protection_level
);

  // Whole state of the block
  typedef struct packed {
    logic        sampled;      // Level taken since reset
    fsbc_level_t level;        // Held protection level
    logic        ea_latch;     // Pin value caught at sampling
    logic [15:0] boot_addr;    // Start address chosen at sampling
    logic [7:0]  hardware_security_copy;          // Hardware security byte
    logic [7:0]  boot_vector_copy;          // Boot vector copy
    logic [7:0]  hsbc;         // Security byte copy
    logic [7:0]  boot_status_byte;          // Boot status byte
    logic [7:0]  software_lock_byte;          // Software lock byte
    logic        pp_done;
    logic        pp_grant;
    logic        pp_refused;
    logic [7:0]  pp_rdata;
    logic        isp_done;
    logic        isp_grant;
    logic        isp_refused;
    logic [7:0]  isp_rdata;
    logic        fetch_external;
    logic        fetch_denied;
    logic        code_read_denied;
  } fsbc_state_t;

  // Reset image; storage comes up as a delivered part
  localparam fsbc_state_t STATE_RST = '{
    level: FSBC_LVL4, boot_addr: BOOT_LOADER,
    hardware_security_copy: HSB_DELIVERED,
    boot_vector_copy: SBV_RST, hsbc: HSBC_RST, boot_status_byte: BSB_RST, software_lock_byte: SSB_RST,
    default: '0};

  fsbc_state_t q;          // Registered state
  fsbc_state_t n;          // Next state
  logic        ea_sync;    // Synchronised pin
  logic        ea_high;    // Pin as the fetch logic sees it
  logic        go_ext;     // Fetch goes outside
  logic        exec_denied;
  logic        read_denied;
  fsbc_level_t sw_lvl;     // Software lock level
  logic        ok;         // Command allowed

  // Pin arrives asynchronously
  fsbc_sync u_ea_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .pin_in   (external_access_pin),
    .pin_sync (ea_sync)
  );

  // Locked parts use the pin value caught at sampling
  assign ea_high = (q.level != FSBC_LVL1) ? q.ea_latch : ea_sync;
  assign sw_lvl  = fsbc_sw_level(q.software_lock_byte[1:0]);

  fsbc_fetch_route u_route (
    .ea_high            (ea_high),
    .level              (q.level),
    .large_part         (LARGE_PART),
    .fetch_pc           (fetch_pc),
    .code_read_addr     (code_read_addr),
    .code_read_from_ext (code_read_from_ext),
    .go_external        (go_ext),
    .exec_denied        (exec_denied),
    .read_denied        (read_denied)
  );

  // Extra array and identity read, shared by both programming paths
  function automatic logic [7:0] xaf_rd(input fsbc_state_t s, input logic [2:0] i);
    unique case (i)
      XAF_SBV:  return s.boot_vector_copy;
      XAF_HSBC: return s.hsbc;
      XAF_BSB:  return s.boot_status_byte;
      XAF_SSB:  return s.software_lock_byte;
      default:  return ID_BYTES[{i[1:0], 3'b000} +: 8];
    endcase
  endfunction

  // Extra array write; identity bytes are read only
  function automatic fsbc_state_t xaf_wr(input fsbc_state_t s, input logic [2:0] i,
                                        input logic [7:0] d);
    fsbc_state_t r;
    r = s;
    unique case (i)
      XAF_SBV:  r.boot_vector_copy = d;
      XAF_HSBC: r.hsbc = d;
      XAF_BSB:  r.boot_status_byte = d;
      // Reserved bits stay one; lock bits can only be programmed
      XAF_SSB:  r.software_lock_byte = {SSB_RSVD, s.software_lock_byte[1:0] & d[1:0]};
      default:  r = s;
    endcase
    return r;
  endfunction

  // Next state: sampling, command gates, fetch routing
  always_comb
  begin
    n = q;
    ok = 1'b0;
    n.pp_done = 1'b0;
    n.pp_grant = 1'b0;
    n.pp_refused = 1'b0;
    n.isp_done = 1'b0;
    n.isp_grant = 1'b0;
    n.isp_refused = 1'b0;
    // Fetch answers every cycle, one cycle late
    n.fetch_external = fetch_req & go_ext;
    n.fetch_denied = fetch_req & exec_denied;
    n.code_read_denied = code_read_req & read_denied;
    if (!q.sampled)
    begin
      // First edge after reset: freeze level, pin and boot address
      n.sampled = 1'b1;
      n.level = fsbc_hw_level(q.hardware_security_copy[2:0]);
      n.ea_latch = ea_sync;
      n.boot_addr = q.hardware_security_copy[HSB_BOOT_BIT] ? BOOT_APP : BOOT_LOADER;
    end
    else
    begin
      // In-system path, governed by the software byte
      if (isp_req)
      begin
        n.isp_done = 1'b1;
        unique case (isp_cmd)
          ISP_PROG_FLASH:
          begin
            // Serial loader also blocked from hardware level 3; API is not
            ok = (sw_lvl == FSBC_LVL1) &&
                 (isp_api || q.level < FSBC_LVL3);
          end
          ISP_VERIFY:   ok = (sw_lvl != FSBC_LVL3);
          ISP_READ_XAF:
          begin
            ok = 1'b1;
            n.isp_rdata = xaf_rd(q, isp_index);
          end
          ISP_PROG_XAF:
          begin
            ok = 1'b1;
            n = xaf_wr(n, isp_index, isp_wdata);
          end
        endcase
        n.isp_grant = ok;
        n.isp_refused = !ok;
      end
      // Parallel path, governed by the hardware level; wins on a clash
      if (pp_req)
      begin
        n.pp_done = 1'b1;
        ok = 1'b1;
        unique case (pp_cmd)
          PP_READ_FLASH:  ok = (q.level < FSBC_LVL3);
          PP_PROG_FLASH,
          PP_PROG_EEPROM: ok = (q.level == FSBC_LVL1);
          PP_READ_ID:     n.pp_rdata = xaf_rd(q, {1'b1, pp_index[1:0]});
          PP_CHIP_ERASE:
          begin
            // Erase unlocks everything at once
            n.hardware_security_copy = HSB_ERASED;
            n.level = FSBC_LVL1;
            n.software_lock_byte = SSB_RST;
          end
          PP_PROG_HSB:    n.hardware_security_copy = q.hardware_security_copy & pp_wdata; // Boot and lock bits take effect next sample; clock and oscillator bits at once
          PP_READ_HSB:    n.pp_rdata = q.hardware_security_copy;
          PP_READ_XAF:    n.pp_rdata = xaf_rd(q, pp_index);
          PP_PROG_XAF:    n = xaf_wr(n, pp_index, pp_wdata);
          default:        ok = 1'b0;
        endcase
        n.pp_done = 1'b1;
        n.pp_grant = ok;
        n.pp_refused = !ok;
      end
      // Warm restart re-samples the stored byte
      if (resample_req)
        n.sampled = 1'b0;
    end
  end

  // Single state register
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      q <= STATE_RST;
    else
      q <= n;
  end

  // Outputs straight from the state register
  assign pp_done = q.pp_done;
  assign pp_grant = q.pp_grant;
  assign pp_refused = q.pp_refused;
  assign pp_rdata = q.pp_rdata;
  assign isp_done = q.isp_done;
  assign isp_grant = q.isp_grant;
  assign isp_refused = q.isp_refused;
  assign isp_rdata = q.isp_rdata;
  assign fetch_external = q.fetch_external;
  assign fetch_denied = q.fetch_denied;
  assign code_read_denied = q.code_read_denied;
  assign boot_addr = q.boot_addr;
  assign double_speed_select = !q.hardware_security_copy[HSB_SPEED_BIT];
  assign oscillator_range = q.hardware_security_copy[HSB_OSC_HI:HSB_OSC_LO];
  assign protection_level = q.level;

  // Checks on the block's own behaviour
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_pp(fsbc_pp_cmd_t c);
    pp_req && q.sampled && pp_cmd == c;
  endsequence

  sequence s_refuse;
    pp_done && pp_refused && !pp_grant;
  endsequence

  property p_boot_addr;
    $rose(q.sampled) |-> boot_addr == ($past(q.hardware_security_copy[HSB_BOOT_BIT]) ? BOOT_APP : BOOT_LOADER);
  endproperty
  a_boot_addr: assert property (p_boot_addr) else $error("boot address wrong");

  property p_level_map;
    $rose(q.sampled) |-> q.level == fsbc_hw_level($past(q.hardware_security_copy[2:0]));
  endproperty
  a_level_map: assert property (p_level_map) else $error("level decode wrong");

  property p_level_hold;
    q.sampled && !resample_req && !(pp_req && pp_cmd == PP_CHIP_ERASE)
      |=> $stable(q.level);
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("level changed");

  property p_pp_prog;
    s_pp(PP_PROG_FLASH) and (q.level != FSBC_LVL1) |=> s_refuse;
  endproperty
  a_pp_prog: assert property (p_pp_prog) else $error("parallel program allowed");

  property p_pp_verify;
    s_pp(PP_READ_FLASH) and (q.level >= FSBC_LVL3) |=> s_refuse;
  endproperty
  a_pp_verify: assert property (p_pp_verify) else $error("parallel verify allowed");

  property p_ext_exec;
    fetch_req && go_ext && q.level == FSBC_LVL4 |=> fetch_denied && fetch_external;
  endproperty
  a_ext_exec: assert property (p_ext_exec) else $error("external run allowed");

  property p_erase;
    s_pp(PP_CHIP_ERASE) |=> q.hardware_security_copy == HSB_ERASED && protection_level == FSBC_LVL1 ##1
      pp_done == 1'b0 || pp_req;
  endproperty
  a_erase: assert property (p_erase) else $error("erase did not unlock");

  property p_id;
    s_pp(PP_READ_ID) |=> pp_grant && !pp_refused;
  endproperty
  a_id: assert property (p_id) else $error("identity refused");

  property p_isp_prog;
    isp_req && q.sampled && isp_cmd == ISP_PROG_FLASH && sw_lvl != FSBC_LVL1
      |=> isp_done && isp_refused;
  endproperty
  a_isp_prog: assert property (p_isp_prog) else $error("isp program allowed");

  property p_isp_verify;
    isp_req && q.sampled && isp_cmd == ISP_VERIFY && !q.software_lock_byte[1] |=> isp_refused;
  endproperty
  a_isp_verify: assert property (p_isp_verify) else $error("isp verify allowed");

  property p_ssb_rsvd;
    q.software_lock_byte[7:2] == SSB_RSVD;
  endproperty
  a_ssb_rsvd: assert property (p_ssb_rsvd) else $error("reserved bit cleared");

  property p_ea_low;
    fetch_req && !ea_high |=> fetch_external;
  endproperty
  a_ea_low: assert property (p_ea_low) else $error("low pin fetched inside");

  property p_inside;
    fetch_req && ea_high && fetch_pc <= (LARGE_PART ? TOP_32K : TOP_16K) |=> !fetch_external;
  endproperty
  a_inside: assert property (p_inside) else $error("internal fetch sent out");

endmodule // fsbc_top

// ==== hdl/fsbc_pkg.sv ====
// Shared constants, types and decode functions for the flash security block
package fsbc_pkg;

  // Hardware security byte as delivered and after chip erase
  localparam logic [7:0]  HSB_DELIVERED = 8'hB8;
  localparam logic [7:0]  HSB_ERASED    = 8'hFF;
  // Field positions inside the hardware security byte
  localparam int          HSB_SPEED_BIT = 7;
  localparam int          HSB_BOOT_BIT  = 6;
  localparam int          HSB_OSC_HI    = 5;
  localparam int          HSB_OSC_LO    = 4;
  // Extra array copies after reset
  localparam logic [7:0]  SBV_RST       = 8'hFC;
  localparam logic [7:0]  HSBC_RST      = 8'hB8;
  localparam logic [7:0]  BSB_RST       = 8'hFF;
  localparam logic [7:0]  SSB_RST       = 8'hFF;
  localparam logic [5:0]  SSB_RSVD      = 6'h3F;
  // Extra array index map
  localparam logic [2:0]  XAF_SBV       = 3'h0;
  localparam logic [2:0]  XAF_HSBC      = 3'h1;
  localparam logic [2:0]  XAF_BSB       = 3'h2;
  localparam logic [2:0]  XAF_SSB       = 3'h3;
  // Boot addresses
  localparam logic [15:0] BOOT_APP      = 16'h0000;
  localparam logic [15:0] BOOT_LOADER   = 16'hF400;
  // Last internal address of each part size
  localparam logic [15:0] TOP_16K       = 16'h3FFF;
  localparam logic [15:0] TOP_32K       = 16'h7FFF;

  // Protection levels one to four
  typedef enum logic [1:0] {FSBC_LVL1, FSBC_LVL2, FSBC_LVL3, FSBC_LVL4} fsbc_level_t;

  // Parallel programmer commands
  typedef enum logic [3:0] {
    PP_READ_FLASH, PP_PROG_FLASH, PP_PROG_EEPROM, PP_READ_ID, PP_CHIP_ERASE,
    PP_PROG_HSB, PP_READ_HSB, PP_READ_XAF, PP_PROG_XAF
  } fsbc_pp_cmd_t;

  // In-system programming commands
  typedef enum logic [1:0] {ISP_PROG_FLASH, ISP_VERIFY, ISP_READ_XAF, ISP_PROG_XAF} fsbc_isp_cmd_t;

  // Hardware lock bits to level; a zero bit is programmed, highest wins
  function automatic fsbc_level_t fsbc_hw_level(input logic [2:0] lb);
    if (!lb[2])      return FSBC_LVL4;
    else if (!lb[1]) return FSBC_LVL3;
    else if (!lb[0]) return FSBC_LVL2;
    else             return FSBC_LVL1;
  endfunction

  // Software lock bits to level
  function automatic fsbc_level_t fsbc_sw_level(input logic [1:0] lb);
    if (!lb[1])      return FSBC_LVL3;
    else if (!lb[0]) return FSBC_LVL2;
    else             return FSBC_LVL1;
  endfunction

endpackage

// ==== hdl/fsbc_sync.sv ====
// Two-stage synchroniser for a level arriving from a pin
`timescale 1ns/10ps
module fsbc_sync
  import fsbc_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic pin_in,
  output logic      pin_sync
);

  // Both stages in one state word
  typedef struct packed {
    logic s1;
    logic s2;
  } fsbc_sync_t;

  fsbc_sync_t st_q;
  fsbc_sync_t st_d;

  // First stage feeds only the second
  always_comb
  begin
    st_d    = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
  end

  // Register the stages
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    // Reset to the pin's idle high level, so the level latched on the
    // first edge after reset matches an undriven internal-fetch setup
    if (!reset_n)
      st_q <= '1;
    else
      st_q <= st_d;
  end

  assign pin_sync = st_q.s2;

endmodule // fsbc_sync

// ==== hdl/fsbc_fetch_route.sv ====
// Splits program fetches between internal flash and external memory
`timescale 1ns/10ps
module fsbc_fetch_route
  import fsbc_pkg::*;
(
  input  wire logic        ea_high,
  input  wire fsbc_level_t level,
  input  wire logic        large_part,
  input  wire logic [15:0] fetch_pc,
  input  wire logic [15:0] code_read_addr,
  input  wire logic        code_read_from_ext,
  output logic             go_external,
  output logic             exec_denied,
  output logic             read_denied
);

  logic [15:0] top_addr;  // Last internal address

  // Pick the part size boundary
  always_comb
  begin
    top_addr = large_part ? TOP_32K : TOP_16K;
  end

  // Low pin forces external; otherwise past the top goes external
  assign go_external = !ea_high || (fetch_pc > top_addr);
  // Top level forbids any external execution
  assign exec_denied = go_external && (level == FSBC_LVL4);
  // Above level one, code reads run from outside may not see internal bytes
  assign read_denied = code_read_from_ext && (level != FSBC_LVL1) &&
                       (code_read_addr <= top_addr) && ea_high;

endmodule // fsbc_fetch_route

// ==== verification/fsbc_prog_model.sv ====
// Programmer and loader model that issues byte commands to the block
`timescale 1ns/10ps
module fsbc_prog_model
  import fsbc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       pp_done,
  input  wire logic       pp_grant,
  input  wire logic       pp_refused,
  input  wire logic [7:0] pp_rdata,
  input  wire logic       isp_done,
  input  wire logic       isp_grant,
  input  wire logic       isp_refused,
  input  wire logic [7:0] isp_rdata,
  output fsbc_pp_cmd_t    pp_cmd,
  output logic            pp_req,
  output logic [2:0]      pp_index,
  output logic [7:0]      pp_wdata,
  output fsbc_isp_cmd_t   isp_cmd,
  output logic            isp_req,
  output logic            isp_api,
  output logic [2:0]      isp_index,
  output logic [7:0]      isp_wdata
);
  // Quiet request lines at power-up
  initial
  begin
    pp_req    = 1'b0;
    isp_req   = 1'b0;
    pp_cmd    = PP_READ_FLASH;
    isp_cmd   = ISP_VERIFY;
    isp_api   = 1'b0;
    pp_index  = 3'h0;
    isp_index = 3'h0;
    pp_wdata  = 8'h00;
    isp_wdata = 8'h00;
  end

  // One command; gap idles first so slow hosts are covered too
  task automatic op(input logic sel, input logic [3:0] c, input logic api,
                    input logic [2:0] idx, input logic [7:0] wd, input int gap,
                    output logic [2:0] res, output logic [7:0] rd);
    int n;
    res = 3'b000;
    rd  = 8'h00;
    repeat (gap) @(posedge core_clk);
    @(posedge core_clk);
    if (sel)
    begin
      isp_req   <= 1'b1;
      isp_cmd   <= fsbc_isp_cmd_t'(c[1:0]);
      isp_api   <= api;
      isp_index <= idx;
      isp_wdata <= wd;
    end
    else
    begin
      pp_req   <= 1'b1;
      pp_cmd   <= fsbc_pp_cmd_t'(c);
      pp_index <= idx;
      pp_wdata <= wd;
    end
    // Taken on this edge; a second cycle high would be a second command
    @(posedge core_clk);
    pp_req  <= 1'b0;
    isp_req <= 1'b0;
    // Bounded wait for the answer pulse
    for (n = 0; n < 4 && !res[2]; n++)
    begin
      #1;
      if (sel ? isp_done : pp_done)
      begin
        res = sel ? {1'b1, isp_grant, isp_refused} : {1'b1, pp_grant, pp_refused};
        rd  = sel ? isp_rdata : pp_rdata;
      end
      else
        @(posedge core_clk);
    end
    // Released data lines flip so a stale byte never passes as fresh
    pp_wdata  <= ~pp_wdata;
    isp_wdata <= ~isp_wdata;
  endtask
endmodule // fsbc_prog_model

// ==== verification/testbench.sv ====
// Scenario bench for the flash security and boot configuration block
`timescale 1ns/10ps
module testbench;
  import fsbc_pkg::*;
  localparam logic [31:0] ID = 32'hA5C3_0F96; // Arbitrary identity bytes
  localparam logic [7:0] XDEF [4] = '{8'hFC, 8'hB8, 8'hFF, 8'hFF};
  logic          core_clk, reset_n, resample_req, external_access_pin;
  logic          fetch_req, code_read_req, code_read_from_ext, pp_req, isp_req, isp_api;
  logic [15:0]   fetch_pc, code_read_addr, boot_addr;
  fsbc_pp_cmd_t  pp_cmd;
  fsbc_isp_cmd_t isp_cmd;
  logic [2:0]    pp_index, isp_index, res;
  logic [7:0]    pp_wdata, isp_wdata, pp_rdata, isp_rdata, rd;
  logic          pp_done, pp_grant, pp_refused, isp_done, isp_grant, isp_refused;
  logic          fetch_external, fetch_denied, code_read_denied, double_speed_select;
  logic [1:0]    oscillator_range, protection_level;
  int            fails, checks_done, gap, i;

  fsbc_top #(.LARGE_PART(1'b1), .ID_BYTES(ID)) dut (
    .core_clk(core_clk), .reset_n(reset_n), .resample_req(resample_req),
    .external_access_pin(external_access_pin), .fetch_req(fetch_req),
    .fetch_pc(fetch_pc), .code_read_req(code_read_req), .code_read_addr(code_read_addr),
    .code_read_from_ext(code_read_from_ext), .pp_req(pp_req), .pp_cmd(pp_cmd),
    .pp_index(pp_index), .pp_wdata(pp_wdata), .isp_req(isp_req), .isp_cmd(isp_cmd),
    .isp_api(isp_api), .isp_index(isp_index), .isp_wdata(isp_wdata),
    .pp_done(pp_done), .pp_grant(pp_grant), .pp_refused(pp_refused),
    .pp_rdata(pp_rdata), .isp_done(isp_done), .isp_grant(isp_grant),
    .isp_refused(isp_refused), .isp_rdata(isp_rdata), .fetch_external(fetch_external),
    .fetch_denied(fetch_denied), .code_read_denied(code_read_denied),
    .boot_addr(boot_addr), .double_speed_select(double_speed_select),
    .oscillator_range(oscillator_range), .protection_level(protection_level));

  fsbc_prog_model u_prog (
    .core_clk(core_clk), .pp_done(pp_done), .pp_grant(pp_grant),
    .pp_refused(pp_refused), .pp_rdata(pp_rdata), .isp_done(isp_done),
    .isp_grant(isp_grant), .isp_refused(isp_refused), .isp_rdata(isp_rdata),
    .pp_cmd(pp_cmd), .pp_req(pp_req), .pp_index(pp_index), .pp_wdata(pp_wdata),
    .isp_cmd(isp_cmd), .isp_req(isp_req), .isp_api(isp_api),
    .isp_index(isp_index), .isp_wdata(isp_wdata));

  // 100 MHz core clock
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  // Compare and count
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      fails++;
    end
  endtask
  task automatic chkb(input string nm, input logic e, input logic g);
    chk(nm, 16'(e), 16'(g));
  endtask

  // Verdict and end of run
  task automatic results();
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One command through the model; a lost answer ends the run
  task automatic cmd(input logic sel, input logic [3:0] c, input logic api,
                     input logic [2:0] x, input logic [7:0] w, input logic g);
    u_prog.op(sel, c, api, x, w, gap, res, rd);
    chkb("done", 1'b1, res[2]);
    if (res[2] !== 1'b1)
      results();
    chkb("grant", g, res[1]);
    chkb("refused", !g, res[0]);
  endtask
  task automatic pp(input fsbc_pp_cmd_t c, input logic [2:0] x, input logic [7:0] w,
                    input logic g);
    cmd(1'b0, 4'(c), 1'b0, x, w, g);
  endtask
  task automatic in_system_programming(input fsbc_isp_cmd_t c, input logic a, input logic [2:0] x,
                     input logic [7:0] w, input logic g);
    cmd(1'b1, 4'(c), a, x, w, g);
  endtask

  // Fetch and code-read probes, answer one cycle later
  task automatic fetch(input logic [15:0] pc, input logic ext, input logic den);
    @(posedge core_clk);
    fetch_req <= 1'b1;
    fetch_pc  <= pc;
    @(posedge core_clk);
    fetch_req <= 1'b0;
    #1;
    chkb("fetch_external", ext, fetch_external);
    chkb("fetch_denied", den, fetch_denied);
  endtask
  task automatic cread(input logic [15:0] a, input logic fx, input logic den);
    @(posedge core_clk);
    code_read_req      <= 1'b1;
    code_read_addr     <= a;
    code_read_from_ext <= fx;
    @(posedge core_clk);
    code_read_req <= 1'b0;
    #1;
    chkb("code_read_denied", den, code_read_denied);
  endtask

  // Warm restart; level is sampled again
  task automatic resample();
    @(posedge core_clk);
    resample_req <= 1'b1;
    @(posedge core_clk);
    resample_req <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  // Pin change, then room for the two-stage synchroniser
  task automatic pin(input logic v);
    @(posedge core_clk);
    external_access_pin <= v;
    repeat (4) @(posedge core_clk);
  endtask

  // Delivered state and extra array defaults
  task automatic t_delivered();
    chk("level", 16'h0003, 16'(protection_level));
    chk("boot_addr", 16'hF400, boot_addr);
    chkb("double_speed_select", 1'b0, double_speed_select);
    chk("oscillator_range", 16'h0003, 16'(oscillator_range));
    pp(PP_READ_HSB, 3'h0, 8'h00, 1'b1);
    chk("hsb", 16'h00B8, 16'(rd));
    for (i = 0; i < 4; i++)
    begin
      pp(PP_READ_XAF, 3'(i), 8'h00, 1'b1);
      chk("xaf", 16'(XDEF[i]), 16'(rd));
    end
    $display("done t_delivered");
  endtask

  // Level four refusals, identity and routing
  task automatic t_level4();
    pp(PP_PROG_FLASH, 3'h0, 8'h55, 1'b0);
    pp(PP_PROG_EEPROM, 3'h0, 8'h55, 1'b0);
    pp(PP_READ_FLASH, 3'h0, 8'h00, 1'b0);
    for (i = 0; i < 4; i++)
    begin
      pp(PP_READ_ID, 3'(i), 8'h00, 1'b1);
      chk("id", 16'(ID[8*i +: 8]), 16'(rd));
    end
    in_system_programming(ISP_PROG_FLASH, 1'b0, 3'h0, 8'h12, 1'b0);
    in_system_programming(ISP_PROG_FLASH, 1'b1, 3'h0, 8'h12, 1'b1);
    fetch(16'h8000, 1'b1, 1'b1);
    fetch(16'h0100, 1'b0, 1'b0);
    cread(16'h0100, 1'b1, 1'b1);
    $display("done t_level4");
  endtask

  // Erase before new code, then level one behaviour
  task automatic t_erase();
    pp(PP_CHIP_ERASE, 3'h0, 8'h00, 1'b1);
    chk("level", 16'h0000, 16'(protection_level));
    pp(PP_READ_HSB, 3'h0, 8'h00, 1'b1);
    chk("hsb", 16'h00FF, 16'(rd));
    resample();
    chk("boot_addr", 16'h0000, boot_addr);
    pp(PP_PROG_FLASH, 3'h0, 8'hA5, 1'b1);
    pp(PP_READ_FLASH, 3'h0, 8'h00, 1'b1);
    cread(16'h0100, 1'b1, 1'b0);
    fetch(16'h7FFF, 1'b0, 1'b0);
    fetch(16'h8000, 1'b1, 1'b0);
    pin(1'b0);
    fetch(16'h0100, 1'b1, 1'b0);
    pin(1'b1);
    $display("done t_erase");
  endtask

  // Software lock byte gates the in-system path only
  task automatic t_sw_lock();
    in_system_programming(ISP_PROG_FLASH, 1'b0, 3'h0, 8'h3C, 1'b1);
    in_system_programming(ISP_PROG_XAF, 1'b1, 3'h2, 8'h00, 1'b1);
    in_system_programming(ISP_READ_XAF, 1'b1, 3'h2, 8'h00, 1'b1);
    chk("boot_status", 16'h0000, 16'(rd));
    in_system_programming(ISP_PROG_XAF, 1'b1, 3'h3, 8'h02, 1'b1);
    in_system_programming(ISP_READ_XAF, 1'b1, 3'h3, 8'h00, 1'b1);
    chk("sw_lock", 16'h00FE, 16'(rd));
    in_system_programming(ISP_PROG_FLASH, 1'b1, 3'h0, 8'h3C, 1'b0);
    in_system_programming(ISP_VERIFY, 1'b0, 3'h0, 8'h00, 1'b1);
    in_system_programming(ISP_PROG_XAF, 1'b1, 3'h3, 8'hFD, 1'b1);
    in_system_programming(ISP_READ_XAF, 1'b1, 3'h3, 8'h00, 1'b1);
    chk("sw_lock", 16'h00FC, 16'(rd));
    in_system_programming(ISP_VERIFY, 1'b0, 3'h0, 8'h00, 1'b0);
    in_system_programming(ISP_PROG_FLASH, 1'b1, 3'h0, 8'h3C, 1'b0);
    pp(PP_PROG_FLASH, 3'h0, 8'hA5, 1'b1);
    $display("done t_sw_lock");
  endtask

  // Level two with six-clock mode, pin latched at sampling
  task automatic t_level2();
    pp(PP_CHIP_ERASE, 3'h0, 8'h00, 1'b1);
    pp(PP_PROG_HSB, 3'h0, 8'h7E, 1'b1);
    resample();
    chk("level", 16'h0001, 16'(protection_level));
    chkb("double_speed_select", 1'b1, double_speed_select);
    chk("boot_addr", 16'h0000, boot_addr);
    pp(PP_PROG_FLASH, 3'h0, 8'hA5, 1'b0);
    pp(PP_PROG_EEPROM, 3'h0, 8'hA5, 1'b0);
    pp(PP_READ_FLASH, 3'h0, 8'h00, 1'b1);
    in_system_programming(ISP_PROG_FLASH, 1'b0, 3'h0, 8'h3C, 1'b1);
    cread(16'h0100, 1'b1, 1'b1);
    cread(16'h0100, 1'b0, 1'b0);
    pin(1'b0);
    fetch(16'h0100, 1'b0, 1'b0);
    pin(1'b1);
    $display("done t_level2");
  endtask

  // Level three with a slow host
  task automatic t_level3();
    gap = 3;
    pp(PP_PROG_HSB, 3'h0, 8'hFD, 1'b1);
    chk("level", 16'h0001, 16'(protection_level));
    resample();
    chk("level", 16'h0002, 16'(protection_level));
    pp(PP_READ_FLASH, 3'h0, 8'h00, 1'b0);
    pp(PP_READ_ID, 3'h1, 8'h00, 1'b1);
    chk("id", 16'(ID[15:8]), 16'(rd));
    in_system_programming(ISP_PROG_FLASH, 1'b0, 3'h0, 8'h3C, 1'b0);
    in_system_programming(ISP_PROG_FLASH, 1'b1, 3'h0, 8'h3C, 1'b1);
    fetch(16'h8000, 1'b1, 1'b0);
    gap = 0;
    $display("done t_level3");
  endtask

  // Main sequence
  initial
  begin
    fails = 0;
    checks_done = 0;
    gap = 0;
    reset_n = 1'b0;
    resample_req = 1'b0;
    external_access_pin = 1'b1;
    fetch_req = 1'b0;
    fetch_pc = 16'h0000;
    code_read_req = 1'b0;
    code_read_addr = 16'h0000;
    code_read_from_ext = 1'b0;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    t_delivered();
    t_level4();
    t_erase();
    t_sw_lock();
    t_level2();
    t_level3();
    results();
  end
endmodule // testbench
